// [rtl/dspmul_pkg.sv]
/*
 * Constants and types for the core multiplier.
 * Assumes a single core clock and a synchronous active-high reset.
 */
package dspmul_pkg;
    localparam int OPND_W = 16;
    localparam int EXT_W = 17;
    localparam int PROD_W = 34;
    localparam int RES_W = 32;
    localparam int ACC_W = 40;
    localparam int BYTE_W = 8;
    localparam int FRAC_SHIFT = 1;
    localparam int PIPE_LAT = 1;
    localparam logic [OPND_W-1:0] Q15_MINUS_ONE = 16'h8000;
    localparam logic [RES_W-1:0] RES_RESET = 32'h0000_0000;
    localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
endpackage

// [rtl/dspmul_core.sv]
/*
 * Core multiplier: 17x17 signed multiply with operand extension, output
 * scaler for 1.31 fraction or 32-bit integer, 40-bit accumulator feed,
 * byte/word integer multiply and a two-accumulator 40-bit adder.
 * Assumes the decoder presents operands and controls with op_valid for one
 * cycle; results appear one cycle later.
 */
// Summary of operation
// - Two 17-bit extended operands are multiplied signed or unsigned as the operation selects.
// - An unsigned operand gets zero in its seventeenth bit.
// - A signed operand gets its top bit copied into its seventeenth bit.
// - The output scaler gives a 1.31 fraction in fractional mode, a 16-bit integer in byte mode and a 32-bit integer otherwise.
// - Products to the accumulator path are extended to 40 bits: zero for unsigned x unsigned integer products and for byte products, sign otherwise.
// - Integer data is two's complement with the top bit as sign.
// - Fractional operands are Q15 with 0x8000 meaning -1.0.
// - A fractional 16x16 multiply is aligned to a 1.31 product.
// - The same multiplier runs signed, unsigned and mixed-sign integer multiplies.
// - Byte operands give a 16-bit result and word operands a 32-bit result.
// - A 40-bit adder/subtracter accumulates products into accumulator A or B.
`timescale 1ns/1ns
`default_nettype none
module dspmul_core
    import dspmul_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic op_valid,
    input wire logic [OPND_W-1:0] opnd_a,
    input wire logic [OPND_W-1:0] opnd_b,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic frac_mode,
    input wire logic byte_mode,
    input wire logic acc_en,
    input wire logic acc_sub,
    input wire logic acc_sel,
    output logic res_valid,
    output logic [RES_W-1:0] result,
    output logic [ACC_W-1:0] prod_ext,
    output logic [ACC_W-1:0] acc_a,
    output logic [ACC_W-1:0] acc_b
);

    ////////////////////////////////////////////////////////////////////////
    // operand extension and multiply
    logic [OPND_W-1:0] in_a;
    logic [OPND_W-1:0] in_b;
    logic [EXT_W-1:0] ext_a;
    logic [EXT_W-1:0] ext_b;
    logic signed [PROD_W-1:0] prod;
    logic [RES_W-1:0] scaled;
    logic [ACC_W-1:0] scaled_ext;
    logic eff_a_signed;
    logic eff_b_signed;

    always_comb begin
        // byte operands live in the low byte
        // byte mode under fractional mode is undefined; extension follows a_signed/b_signed only
        if (byte_mode) begin
            in_a = {{BYTE_W{a_signed & opnd_a[BYTE_W-1]}}, opnd_a[BYTE_W-1:0]};
            in_b = {{BYTE_W{b_signed & opnd_b[BYTE_W-1]}}, opnd_b[BYTE_W-1:0]};
        end else begin
            in_a = opnd_a;
            in_b = opnd_b;
        end
        // fractional data is always signed Q15
        eff_a_signed = a_signed | frac_mode;
        eff_b_signed = b_signed | frac_mode;
        ext_a = {eff_a_signed & in_a[OPND_W-1], in_a};
        ext_b = {eff_b_signed & in_b[OPND_W-1], in_b};
        prod = PROD_W'($signed(ext_a) * $signed(ext_b));
        if (frac_mode) begin
            scaled = RES_W'(prod <<< FRAC_SHIFT);
        end else if (byte_mode) begin
            scaled = {{(RES_W-OPND_W){1'b0}}, prod[OPND_W-1:0]};
        end else begin
            scaled = prod[RES_W-1:0];
        end
        // unsigned x unsigned integer products extend with zero
        // mixed-sign word products still fit 32 signed bits, so bit 31 is a true sign
        if (!frac_mode && !eff_a_signed && !eff_b_signed) begin
            scaled_ext = {{(ACC_W-RES_W){1'b0}}, scaled};
        end else begin
            scaled_ext = {{(ACC_W-RES_W){scaled[RES_W-1]}}, scaled};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result register and accumulators
    logic next_res_valid;
    logic [RES_W-1:0] next_result;
    logic [ACC_W-1:0] next_prod_ext;
    logic [ACC_W-1:0] next_acc_a;
    logic [ACC_W-1:0] next_acc_b;
    logic [ACC_W-1:0] acc_src;
    logic [ACC_W-1:0] acc_sum;

    always_comb begin
        // no saturation: the 40-bit sum wraps, guard bits absorb growth
        acc_src = acc_sel ? acc_b : acc_a;
        acc_sum = acc_sub ? ACC_W'(acc_src - scaled_ext) : ACC_W'(acc_src + scaled_ext);
        // result and prod_ext hold until the next taken op
        next_res_valid = op_valid;
        next_result = op_valid ? scaled : result;
        next_prod_ext = op_valid ? scaled_ext : prod_ext;
        next_acc_a = acc_a;
        next_acc_b = acc_b;
        if (op_valid && acc_en) begin
            if (acc_sel) begin
                next_acc_b = acc_sum;
            end else begin
                next_acc_a = acc_sum;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            res_valid <= 1'b0;
            result <= RES_RESET;
            prod_ext <= ACC_RESET;
            acc_a <= ACC_RESET;
            acc_b <= ACC_RESET;
        end else begin
            res_valid <= next_res_valid;
            result <= next_result;
            prod_ext <= next_prod_ext;
            acc_a <= next_acc_a;
            acc_b <= next_acc_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // reset clears every output
    chk_reset_clear: assert property (@(posedge clk)
        srst
        |=> !res_valid && result == RES_RESET && prod_ext == ACC_RESET
            && acc_a == ACC_RESET && acc_b == ACC_RESET)
        else $error("outputs not cleared by reset");

    // word products
    chk_frac_minus_one: assert property (@(posedge clk) disable iff (srst)
        op_valid && frac_mode && !byte_mode && opnd_a == Q15_MINUS_ONE && opnd_b == Q15_MINUS_ONE
        |=> result == 32'h8000_0000)
        else $error("q15 -1 times -1 wrong");
    chk_unsigned_word: assert property (@(posedge clk) disable iff (srst)
        op_valid && !frac_mode && !byte_mode && !a_signed && !b_signed
        |=> result == RES_W'($past(opnd_a) * $past(opnd_b)))
        else $error("unsigned product wrong");
    chk_signed_word: assert property (@(posedge clk) disable iff (srst)
        op_valid && !frac_mode && !byte_mode && a_signed && b_signed
        |=> $signed(result) == RES_W'($signed($past(opnd_a)) * $signed($past(opnd_b))))
        else $error("signed product wrong");
    chk_mixed_sign: assert property (@(posedge clk) disable iff (srst)
        op_valid && !frac_mode && !byte_mode && a_signed && !b_signed
        |=> $signed(result) == RES_W'($signed($past(opnd_a)) * $signed({1'b0, $past(opnd_b)})))
        else $error("mixed sign product wrong");
    chk_mixed_sign_b: assert property (@(posedge clk) disable iff (srst)
        op_valid && !frac_mode && !byte_mode && !a_signed && b_signed
        |=> $signed(result) == RES_W'($signed({1'b0, $past(opnd_a)}) * $signed($past(opnd_b))))
        else $error("mixed sign b product wrong");
    chk_unsigned_ext: assert property (@(posedge clk) disable iff (srst)
        op_valid && !frac_mode && !a_signed && !b_signed
        |=> prod_ext[ACC_W-1:RES_W] == 8'h00)
        else $error("unsigned product not zero extended");

    // fractional products
    chk_frac_align: assert property (@(posedge clk) disable iff (srst)
        op_valid && frac_mode && !byte_mode
        |=> result == RES_W'(($signed($past(opnd_a)) * $signed($past(opnd_b))) * 2))
        else $error("fraction product not aligned");

    // byte products
    chk_byte_width: assert property (@(posedge clk) disable iff (srst)
        op_valid && byte_mode && !frac_mode
        |=> result[RES_W-1:OPND_W] == 16'h0000)
        else $error("byte result too wide");
    chk_byte_unsigned: assert property (@(posedge clk) disable iff (srst)
        op_valid && byte_mode && !frac_mode && !a_signed && !b_signed
        |=> result[OPND_W-1:0] == OPND_W'($past(opnd_a[BYTE_W-1:0]) * $past(opnd_b[BYTE_W-1:0])))
        else $error("unsigned byte product wrong");
    chk_byte_signed: assert property (@(posedge clk) disable iff (srst)
        op_valid && byte_mode && !frac_mode && a_signed && b_signed
        |=> result[OPND_W-1:0] == OPND_W'($signed($past(opnd_a[BYTE_W-1:0])) * $signed($past(opnd_b[BYTE_W-1:0]))))
        else $error("signed byte product wrong");

    // 40-bit extension and accumulators
    chk_sign_extend: assert property (@(posedge clk) disable iff (srst)
        op_valid && (a_signed || b_signed || frac_mode)
        |=> prod_ext[ACC_W-1:RES_W] == {(ACC_W-RES_W){result[RES_W-1]}})
        else $error("product not sign extended");
    chk_acc_update: assert property (@(posedge clk) disable iff (srst)
        op_valid && acc_en && !acc_sel && !acc_sub
        |=> acc_a == ACC_W'($past(acc_a) + prod_ext) && acc_b == $past(acc_b))
        else $error("accumulator a update wrong");
    chk_acc_b_sub: assert property (@(posedge clk) disable iff (srst)
        op_valid && acc_en && acc_sel && acc_sub
        |=> acc_b == ACC_W'($past(acc_b) - prod_ext) && acc_a == $past(acc_a))
        else $error("accumulator b subtract wrong");
    chk_acc_hold: assert property (@(posedge clk) disable iff (srst)
        !(op_valid && acc_en)
        |=> acc_a == $past(acc_a) && acc_b == $past(acc_b))
        else $error("accumulator changed without a taken op");
    chk_result_hold: assert property (@(posedge clk) disable iff (srst)
        !op_valid
        |=> result == $past(result) && prod_ext == $past(prod_ext))
        else $error("result changed without a taken op");

    // handshake
    chk_valid_latency: assert property (@(posedge clk) disable iff (srst)
        op_valid |=> res_valid ##1 (res_valid == $past(op_valid)))
        else $error("result valid latency wrong");

    // main scenarios
    cov_frac_mac: cover property (@(posedge clk) disable iff (srst) op_valid && frac_mode && acc_en);
    cov_mixed: cover property (@(posedge clk) disable iff (srst) op_valid && a_signed != b_signed);
    cov_byte: cover property (@(posedge clk) disable iff (srst) op_valid && byte_mode);
    cov_acc_b_sub: cover property (@(posedge clk) disable iff (srst) op_valid && acc_en && acc_sel && acc_sub);
    cov_frac_minus_one: cover property (@(posedge clk) disable iff (srst)
        op_valid && frac_mode && opnd_a == Q15_MINUS_ONE && opnd_b == Q15_MINUS_ONE);

endmodule
`default_nettype wire

// [sim/dspmul_src.sv]
/* Decoder model: presents one operation per call, then lets the operands wander.
   Assumes the core samples its inputs at the rising clock edge. */
`timescale 1ns/1ns
`default_nettype none
module dspmul_src
    import dspmul_pkg::*;
(
    input wire logic clk,
    output logic op_valid,
    output logic [OPND_W-1:0] opnd_a,
    output logic [OPND_W-1:0] opnd_b,
    output logic [6:0] ctl
);
    initial begin
        op_valid = 1'b0;
        opnd_a = 16'h0000;
        opnd_b = 16'h0000;
        ctl = 7'h00;
    end
    // ctl packs a_signed, b_signed, frac_mode, byte_mode, acc_en, acc_sub, acc_sel
    task automatic send(input logic [OPND_W-1:0] a, input logic [OPND_W-1:0] b, input logic [6:0] c);
        @(posedge clk);
        op_valid <= 1'b1;
        opnd_a <= a;
        opnd_b <= b;
        ctl <= c;
        @(posedge clk);
        op_valid <= 1'b0;
        opnd_a <= ~a;
        opnd_b <= ~b;
    endtask
endmodule
`default_nettype wire

// [sim/tb_dsp_core_multiplier.sv]
/* Testbench for the core multiplier: signs, fractions, bytes, accumulators.
   Assumes one result one cycle after each taken operation. */
`timescale 1ns/1ns
`default_nettype none
module tb_dsp_core_multiplier
    import dspmul_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    wire logic op_valid, res_valid;
    wire logic [OPND_W-1:0] opnd_a, opnd_b;
    wire logic [6:0] ctl;
    wire logic [RES_W-1:0] result;
    wire logic [ACC_W-1:0] prod_ext, acc_a, acc_b;
    logic [ACC_W-1:0] ea = 40'h00_0000_0000, eb = 40'h00_0000_0000;
    int mismatches = 0, checked = 0;
    dspmul_src i_src (.clk, .op_valid, .opnd_a, .opnd_b, .ctl);
    dspmul_core i_dut (.clk, .srst, .op_valid, .opnd_a, .opnd_b, .a_signed(ctl[6]), .b_signed(ctl[5]),
        .frac_mode(ctl[4]), .byte_mode(ctl[3]), .acc_en(ctl[2]), .acc_sub(ctl[1]), .acc_sel(ctl[0]),
        .res_valid, .result, .prod_ext, .acc_a, .acc_b);
    initial forever #2 clk = ~clk;
    task automatic chk(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_op(input logic [15:0] a, input logic [15:0] b, input logic [6:0] c);
        logic signed [16:0] x, y;
        logic signed [33:0] p;
        logic [31:0] r;
        logic [39:0] pe;
        x = c[3] ? {{9{c[6] & a[7]}}, a[7:0]} : {(c[6] | c[4]) & a[15], a};
        y = c[3] ? {{9{c[5] & b[7]}}, b[7:0]} : {(c[5] | c[4]) & b[15], b};
        p = x * y;
        r = c[3] ? {16'h0000, p[15:0]} : (c[4] ? {p[30:0], 1'b0} : p[31:0]);
        pe = (c[6] | c[5] | c[4]) ? {{8{r[31]}}, r} : {8'h00, r};
        if (c[2] && c[0]) eb = c[1] ? eb - pe : eb + pe;
        if (c[2] && !c[0]) ea = c[1] ? ea - pe : ea + pe;
        i_src.send(a, b, c);
        #1;
        chk({39'h00_0000_0000, res_valid}, 40'h00_0000_0001);
        chk({8'h00, result}, {8'h00, r});
        chk(prod_ext, pe);
        chk(acc_a, ea);
        chk(acc_b, eb);
    endtask
    task automatic t_signs;
        for (int i = 0; i < 4; i++) begin
            do_op(16'h8000, 16'hFFFF, {i[1:0], 5'h00});
        end
    endtask
    task automatic t_frac;
        do_op(16'h8000, 16'h8000, 7'h10);
        do_op(16'h4000, 16'h4000, 7'h10);
        do_op(16'h7FFF, 16'h8000, 7'h70);
        do_op(16'h4000, 16'h4000, 7'h14);
    endtask
    task automatic t_byte;
        do_op(16'hAB80, 16'h12FF, 7'h08);
        do_op(16'hAB80, 16'h12FF, 7'h68);
        do_op(16'h0080, 16'h0001, 7'h68);
    endtask
    task automatic t_acc;
        do_op(16'h7FFF, 16'h7FFF, 7'h64);
        do_op(16'h8000, 16'h7FFF, 7'h64);
        do_op(16'h8000, 16'h7FFF, 7'h67);
        do_op(16'hFFFF, 16'hFFFF, 7'h05);
    endtask
    // mid-run reset: accumulators must restart from zero
    task automatic t_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        ea = 40'h00_0000_0000;
        eb = 40'h00_0000_0000;
        @(posedge clk);
        #1;
        chk(acc_a | acc_b | prod_ext | {8'h00, result}, 40'h00_0000_0000);
        chk({39'h00_0000_0000, res_valid}, 40'h00_0000_0000);
        do_op(16'h0002, 16'h0003, 7'h64);
    endtask
    task automatic finish_test;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk(acc_a | acc_b | prod_ext | {8'h00, result}, 40'h00_0000_0000);
        t_signs();
        t_frac();
        t_byte();
        t_acc();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
